// ===== hcef_top.sv
`timescale 1ns/1ps
// How it works
// - flags sticky, cleared by power-on reset
// - irq needs flag, mask and global enable
// - reading never clears; write-one clears
// - only written ones clear flags
// - read code 24H, write code A4H; the bus reads and writes both at FLAGS_ADDR (090H)
// - bit 9 on dual-role event
// - bit 8 on async threshold or timeout
// - bit 7 on periodic list done with ACK
// - bit 6 when clock restored after suspend
// - bit 5 when core enters suspend
// - control bits 6,7 suspend; stop SOF
// - bit 4 on operational event
// - bit 2 on iso buffer b done
// - bit 1 on iso buffer a done
// - bit 0 on start of frame
// - mask bits reset to zero
module hcef_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // event sources from host core logic
  input wire logic dual_role_evt,
  input wire logic async_count_hit,
  input wire logic async_timeout_hit,
  input wire logic periodic_last_seen,
  input wire logic periodic_ack_seen,
  input wire logic core_woke,
  input wire logic core_clk_running,
  input wire logic core_entered_suspend,
  input wire logic operational_evt,
  input wire logic xfer_byte_dec,
  input wire logic iso_b_last_done,
  input wire logic iso_a_last_done,
  input wire logic sof_state_entry,
  // external pin
  input wire logic end_of_transfer_pin,
  // outputs
  output logic host_irq_pin,
  output logic suspend_req,
  output logic sof_allowed,
  output logic [15:0] transfer_byte_count
);
  // ****************************************
  // bus decode
  // ****************************************
  localparam int NUM_FLAGS_L = hcef_pkg::NUM_FLAGS;
  logic ph_valid_r;
  logic ph_write_r;
  logic [11:0] ph_addr_r;
  logic addr_phase;
  logic wr_en;
  logic rd_en;
  logic [15:0] wdata16;
  logic [15:0] flags_q;
  logic [15:0] mask_r;
  logic [15:0] hwcfg_r;
  logic [15:0] hcctrl_r;
  logic [NUM_FLAGS_L-1:0] flag_bits;
  logic [NUM_FLAGS_L-1:0] set_vec;
  logic [NUM_FLAGS_L-1:0] clr_vec;
  logic eot_sync;
  logic eot_sync_d_r;
  logic xfer_zero_evt;
  logic clr_by_cmd;

  assign addr_phase = hsel && hready && htrans[1];
  assign wr_en = ph_valid_r && ph_write_r;
  assign rd_en = ph_valid_r && !ph_write_r;
  assign wdata16 = hwdata[15:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_addr_r <= '0;
    end else begin
      ph_valid_r <= addr_phase;
      ph_write_r <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mask_r <= hcef_pkg::MASK_RST;
    end else if (wr_en && ph_addr_r == hcef_pkg::MASK_ADDR) begin
      mask_r <= {6'h00, wdata16[9:0]};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hwcfg_r <= hcef_pkg::HWCFG_RST;
    end else if (wr_en && ph_addr_r == hcef_pkg::HWCFG_ADDR) begin
      hwcfg_r <= wdata16;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hcctrl_r <= hcef_pkg::HCCTRL_RST;
    end else if (wr_en && ph_addr_r == hcef_pkg::HCCTRL_ADDR) begin
      hcctrl_r <= wdata16;
    end
  end

  // both suspend bits written high request suspend; no SOF then
  assign suspend_req = hcctrl_r[hcef_pkg::BIT_SUSP_LO] &&
                       hcctrl_r[hcef_pkg::BIT_SUSP_HI];
  assign sof_allowed = !suspend_req;

  // ****************************************
  // transfer byte counter
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      transfer_byte_count <= hcef_pkg::XFER_CNT_RST;
    end else if (wr_en && ph_addr_r == hcef_pkg::CMD_ADDR) begin
      transfer_byte_count <= wdata16;
    end else if (xfer_byte_dec && transfer_byte_count != 16'h0000) begin
      transfer_byte_count <= transfer_byte_count - 16'h0001;
    end
  end

  // pulse when a running count lands on zero (pio or dma)
  assign xfer_zero_evt = xfer_byte_dec &&
                         transfer_byte_count == 16'h0001;

  // ****************************************
  // end-of-transfer pin
  // ****************************************
  hcef_sync #(
    .WIDTH(1)
  ) u_eot_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(end_of_transfer_pin),
    .sync_out(eot_sync)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eot_sync_d_r <= 1'b0;
    end else begin
      eot_sync_d_r <= eot_sync;
    end
  end

  // ****************************************
  // event sources
  // ****************************************
  always_comb begin
    set_vec = '0;
    set_vec[hcef_pkg::BIT_DUAL_ROLE] = dual_role_evt;
    set_vec[hcef_pkg::BIT_ASYNC] = async_count_hit ||
                                   async_timeout_hit;
    set_vec[hcef_pkg::BIT_PERIODIC] = periodic_last_seen &&
                                      periodic_ack_seen;
    set_vec[hcef_pkg::BIT_CLK_RESTORED] = core_woke &&
                                          core_clk_running;
    set_vec[hcef_pkg::BIT_SUSPENDED] = core_entered_suspend;
    set_vec[hcef_pkg::BIT_OPERATIONAL] = operational_evt;
    set_vec[hcef_pkg::BIT_XFER_DONE] = xfer_zero_evt ||
                                       (eot_sync && !eot_sync_d_r);
    set_vec[hcef_pkg::BIT_ISO_B] = iso_b_last_done;
    set_vec[hcef_pkg::BIT_ISO_A] = iso_a_last_done;
    set_vec[hcef_pkg::BIT_SOF] = sof_state_entry;
  end

  // only the write-one path clears; a read has no side effect
  assign clr_by_cmd = wr_en && ph_addr_r == hcef_pkg::FLAGS_ADDR;
  assign clr_vec = clr_by_cmd ? wdata16[NUM_FLAGS_L-1:0] : '0;

  // ****************************************
  // sticky flags
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS_L; gi++) begin : g_flag
      hcef_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .set_evt(set_vec[gi]),
        .clr_req(clr_vec[gi]),
        .flag_r(flag_bits[gi])
      );
    end
  endgenerate

  assign flags_q = {6'h00, flag_bits};

  // ****************************************
  // interrupt pin
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      host_irq_pin <= 1'b0;
    end else begin
      host_irq_pin <= hwcfg_r[hcef_pkg::BIT_GLOBAL_EN] &&
                      |(flag_bits & mask_r[NUM_FLAGS_L-1:0]);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr)
        hcef_pkg::FLAGS_ADDR: hrdata <= {16'h0000, flags_q};
        hcef_pkg::MASK_ADDR: hrdata <= {16'h0000, mask_r};
        hcef_pkg::HWCFG_ADDR: hrdata <= {16'h0000, hwcfg_r};
        hcef_pkg::HCCTRL_ADDR: hrdata <= {16'h0000, hcctrl_r};
        hcef_pkg::CMD_ADDR: hrdata <= {16'h0000, transfer_byte_count};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ===== hcef_pkg.sv
package hcef_pkg;
  // ****************************************
  // register map (word offsets, codes and byte addresses)
  // ****************************************
  localparam logic [7:0] FLAGS_OFS = 8'h24;
  localparam logic [7:0] FLAGS_WR_CODE = 8'hA4;
  localparam logic [7:0] MASK_OFS = 8'h25;
  localparam logic [7:0] MASK_WR_CODE = 8'hA5;
  localparam logic [7:0] HWCFG_OFS = 8'h20;
  localparam logic [7:0] HCCTRL_OFS = 8'h28;
  // byte addresses derived from the offsets as word indices
  localparam logic [11:0] FLAGS_ADDR = 12'h090;
  localparam logic [11:0] MASK_ADDR = 12'h094;
  localparam logic [11:0] HWCFG_ADDR = 12'h080;
  localparam logic [11:0] HCCTRL_ADDR = 12'h0A0;
  localparam logic [11:0] CMD_ADDR = 12'h0C0;
  // ****************************************
  // field positions
  // ****************************************
  localparam int NUM_FLAGS = 10;
  localparam int BIT_DUAL_ROLE = 9;
  localparam int BIT_ASYNC = 8;
  localparam int BIT_PERIODIC = 7;
  localparam int BIT_CLK_RESTORED = 6;
  localparam int BIT_SUSPENDED = 5;
  localparam int BIT_OPERATIONAL = 4;
  localparam int BIT_XFER_DONE = 3;
  localparam int BIT_ISO_B = 2;
  localparam int BIT_ISO_A = 1;
  localparam int BIT_SOF = 0;
  localparam int BIT_GLOBAL_EN = 0;
  localparam int BIT_SUSP_LO = 6;
  localparam int BIT_SUSP_HI = 7;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] HWCFG_RST = 16'h0000;
  localparam logic [15:0] HCCTRL_RST = 16'h0000;
  localparam logic [15:0] XFER_CNT_RST = 16'h0000;
endpackage

// ===== hcef_sync.sv
`timescale 1ns/1ps
module hcef_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // level in and out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ===== hcef_flag.sv
`timescale 1ns/1ps
module hcef_flag (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // event and clear
  input wire logic set_evt,
  input wire logic clr_req,
  // sticky state
  output logic flag_r
);
  logic flag_nxt;

  // set wins over clear
  always_comb begin
    flag_nxt = flag_r;
    if (clr_req) begin
      flag_nxt = 1'b0;
    end
    if (set_evt) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule

// ===== hcef_host.sv
`timescale 1ns/1ps
module hcef_host (
  // clock and answer
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // request
  output logic hsel = 1'b0,
  output logic [11:0] haddr = 12'h000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0000_0000
);
  // one word transfer; flags cleared by writing ones
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
    output logic [31:0] r);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
endmodule

// ===== hcef_top_props.sv
`timescale 1ns/1ps
module hcef_top_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // core side
  input wire logic xfer_byte_dec,
  input wire logic host_irq_pin,
  input wire logic suspend_req,
  input wire logic sof_allowed,
  input wire logic [15:0] transfer_byte_count
);
  logic wr_dp_r;
  logic rd_fl_r;
  logic [3:0] w_cnt_r;
  logic take;
  assign take = hsel & hready & htrans[1];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_dp_r <= 1'b0;
      rd_fl_r <= 1'b0;
    end else begin
      wr_dp_r <= take & hwrite;
      rd_fl_r <= take & !hwrite & (haddr == hcef_pkg::FLAGS_ADDR);
    end
  end
  // cycles since last write data phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) w_cnt_r <= 4'hF;
    else if (wr_dp_r) w_cnt_r <= 4'h0;
    else if (w_cnt_r != 4'hF) w_cnt_r <= w_cnt_r + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_sof_gate: assert property (sof_allowed == !suspend_req)
    else $error("sof gate wrong");
  a_irq_only_write: assert property ($fell(host_irq_pin) |-> w_cnt_r < 4'h3)
    else $error("irq dropped without write");
  a_flag_rsvd: assert property (rd_fl_r |-> hrdata[31:10] == 22'h0)
    else $error("reserved flag bits set");
  a_reset_quiet: assert property ($fell(rst) |-> !host_irq_pin &&
    !suspend_req && transfer_byte_count == 16'h0000)
    else $error("outputs not idle after reset");
  a_count_dec: assert property (xfer_byte_dec && !wr_dp_r &&
    transfer_byte_count != 16'h0000 |=>
    transfer_byte_count == $past(transfer_byte_count) - 16'h0001)
    else $error("count did not step");
  a_count_floor: assert property (xfer_byte_dec && !wr_dp_r &&
    transfer_byte_count == 16'h0000 |=> transfer_byte_count == 16'h0000)
    else $error("count wrapped");
  a_count_hold: assert property (!xfer_byte_dec && !wr_dp_r |=>
    $stable(transfer_byte_count)) else $error("count moved");
  a_susp_hold: assert property (!wr_dp_r |=> $stable(suspend_req))
    else $error("suspend moved");
endmodule
bind hcef_top hcef_top_props u_props (.*);

// ===== test_host_cpu_event_flag_register.sv
`timescale 1ns/1ps
module test_host_cpu_event_flag_register;
  localparam logic [11:0] FL = hcef_pkg::FLAGS_ADDR;
  localparam logic [11:0] MK = hcef_pkg::MASK_ADDR;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hready, hresp, irq, susp, sof, gen;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q, d;
  logic [12:0] ev = 13'h0000;
  logic [15:0] cnt;
  logic [9:0] ef, msk;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 30642;
  int cyc = 0;
  hcef_top u_hcef_top (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .dual_role_evt(ev[9]),
    .async_count_hit(ev[8]), .async_timeout_hit(ev[10]),
    .periodic_last_seen(ev[7] | ev[12]), .periodic_ack_seen(ev[7]),
    .core_woke(ev[6]), .core_clk_running(ev[6]),
    .core_entered_suspend(ev[5]), .operational_evt(ev[4]),
    .xfer_byte_dec(ev[11]), .iso_b_last_done(ev[2]),
    .iso_a_last_done(ev[1]), .sof_state_entry(ev[0]),
    .end_of_transfer_pin(ev[3]), .host_irq_pin(irq),
    .suspend_req(susp), .sof_allowed(sof), .transfer_byte_count(cnt));
  hcef_host u_hcef_host (.core_clk(core_clk), .hready(hready),
    .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  function automatic logic [9:0] f_flag(input int b);
    if (b < 10) return 10'h001 << b;
    return (b == 10) ? 10'h100 : 10'h000;
  endfunction
  function automatic logic f_irq(input logic [9:0] f, m, input logic g);
    return g & (|(f & m));
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] v);
    u_hcef_host.xfer(1'b1, a, v, q);
  endtask
  task rd(input logic [11:0] a);
    u_hcef_host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  task pulse(input logic [12:0] m);
    @(posedge core_clk);
    ev <= m;
    @(posedge core_clk);
    ev <= 13'h0000;
    repeat (5) @(posedge core_clk);
  endtask
  task stop_test;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rd(FL);
    chk(q, 32'h0);
    rd(MK);
    chk(q, 32'h0);
    rd(12'h3FC);
    chk(q, 32'h0);
    $display("reset test done");
    wr(hcef_pkg::HWCFG_ADDR, 32'h1);
    wr(MK, 32'h3FF);
    for (int b = 0; b < 13; b++) begin
      pulse(13'h0001 << b);
      rd(FL);
      chk(q, {22'h0, f_flag(b)});
      chk(irq, f_irq(f_flag(b), 10'h3FF, 1'b1));
      wr(FL, ~{22'h0, f_flag(b)});
      rd(FL);
      chk(q, {22'h0, f_flag(b)});
      wr(FL, {22'h0, f_flag(b)});
      rd(FL);
      chk(q, 32'h0);
    end
    $display("source test done");
    pulse(13'h03FF);
    wr(FL, 32'hFF);
    rd(FL);
    chk(q, 32'h300);
    fork
      wr(FL, 32'h300);
      begin
        repeat (2) @(posedge core_clk);
        ev <= 13'h0200;
        @(posedge core_clk);
        ev <= 13'h0000;
      end
    join
    wr(hcef_pkg::CMD_ADDR, 32'h2);
    pulse(13'h0800);
    pulse(13'h0800);
    chk(cnt, 32'h0);
    rd(FL);
    chk(q, 32'h208);
    for (int k = 0; k < 4; k++) begin
      wr(hcef_pkg::HCCTRL_ADDR, 32'(k) << 6);
      @(negedge core_clk);
      chk(susp, k == 3);
      chk(sof, k != 3);
    end
    $display("corner test done");
    wr(FL, 32'h3FF);
    ef = 10'h000;
    repeat (40) begin
      d = $random(seed);
      pulse({3'h0, d[9:0]});
      ef = ef | d[9:0];
      msk = $random(seed);
      gen = $random(seed);
      wr(MK, {22'h0, msk});
      wr(hcef_pkg::HWCFG_ADDR, {31'h0, gen});
      d = $random(seed);
      wr(FL, d);
      ef = ef & ~d[9:0];
      rd(FL);
      chk(q, {22'h0, ef});
      chk(irq, f_irq(ef, msk, gen));
      rd(MK);
      chk(q, {22'h0, msk});
    end
    $display("random test done");
    stop_test();
  end
endmodule
